// File: pkg/keypad_wake_pkg.sv
// Constants for the keypad wake unit
package keypad_wake_pkg;
    localparam int PIN_COUNT = 5;
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h1B;
    localparam logic [7:0] ADDR_PIN_ENABLE = 8'h21;
    localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
    localparam logic [4:0] PIN_ENABLE_RESET = 5'h00;
    localparam int BIT_SENSITIVITY = 0;
    localparam int BIT_MASK = 1;
    localparam int BIT_ACK = 2;
    localparam int BIT_PENDING = 3;
endpackage

// File: rtl/keypad_wake_unit.sv
// Keypad wake unit: pin sampling, request latch and register file
// ----------------------------------------
// Operation
// ----------------------------------------
// Operation
// - Each pin has its own enable bit
// - Enable bit switches pin pullup on
// - Latch when enabled pin falls, all high before
// - Edge mode ignores edges while another low
// - Level mode clears after ack and pins high
// - Vector fetch acknowledges the request
// - Ack bit acknowledges, always reads zero
// - Edge after ack latches fresh request
// - Mask bit gates request to CPU
// - Edge mode ack clears request at once
// - Reset clears request and mode bit
// - Pending flag readable regardless of mask
// - Enabled pin forced to input
// - Active in wait and stop, wakes CPU
// - Break clear enable allows clearing in break
// - Break without clear enable ignores ack bit
// - Upper four status bits read zero
// - Reset zeroes the status control register
// - Reset clears all pin enables
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module keypad_wake_unit
    import keypad_wake_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic [PIN_COUNT-1:0] keyPin,
    input wire logic [PIN_COUNT-1:0] portDirection,
    input wire logic vectorFetchAck,
    input wire logic breakActive,
    input wire logic breakClearEnable,
    output logic [PIN_COUNT-1:0] pullupEnable,
    output logic [PIN_COUNT-1:0] pinDirection,
    output logic cpuIrq
);

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    // Three stages; a change counts once stages two and three agree
    logic [PIN_COUNT-1:0] syncA;
    logic [PIN_COUNT-1:0] syncB;
    logic [PIN_COUNT-1:0] syncC;
    logic [PIN_COUNT-1:0] pinLevel;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            syncA <= '1;
            syncB <= '1;
            syncC <= '1;
            pinLevel <= '1;
        end else begin
            syncA <= keyPin;
            syncB <= syncA;
            syncC <= syncB;
            pinLevel <= (syncB & syncC) | (pinLevel & (syncB | syncC));
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [PIN_COUNT-1:0] pinWakeEnable;
    logic wakeIrqMask;
    logic sensitivitySelect;
    logic wakePendingFlag;
    logic anyLowPrev;
    logic ackPending;

    wire selStatus = regAddr == ADDR_STATUS_CONTROL;
    wire selEnable = regAddr == ADDR_PIN_ENABLE;
    wire writeStatus = regWrite && selStatus;
    wire writeEnable = regWrite && selEnable;

    // Break without clear enable freezes software acks only
    function automatic logic ack_allowed(input logic inBreak, input logic clearEnable);
        return !(inBreak && !clearEnable);
    endfunction

    // Disabled pins look high so they never trigger
    wire [PIN_COUNT-1:0] enabledLow = pinWakeEnable & ~pinLevel;
    wire anyLow = |enabledLow;
    // Only the first pin to fall from an all-high state latches
    wire fallEvent = anyLow && !anyLowPrev;
    // In break without clear enable the software ack is dropped
    wire softAck = writeStatus && regWdata[BIT_ACK]
        && ack_allowed(breakActive, breakClearEnable);
    wire ackEvent = softAck || vectorFetchAck;
    // Level mode keeps the request while any enabled pin stays low
    wire levelHold = sensitivitySelect && anyLow;
    // An ack seen while pins are low is kept until they all rise
    wire ackHeld = ackEvent || ackPending;
    wire levelClear = ackHeld && !anyLow;
    wire clearReq = sensitivitySelect ? levelClear : ackEvent;
    // Set wins over clear in the same cycle
    wire next_pending = fallEvent || levelHold
        || (wakePendingFlag && !clearReq);
    wire next_ackPending = sensitivitySelect && wakePendingFlag && ackHeld && anyLow;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pinWakeEnable <= PIN_ENABLE_RESET;
            wakeIrqMask <= STATUS_CONTROL_RESET[BIT_MASK];
            sensitivitySelect <= STATUS_CONTROL_RESET[BIT_SENSITIVITY];
            wakePendingFlag <= STATUS_CONTROL_RESET[BIT_PENDING];
            anyLowPrev <= 1'b0;
            ackPending <= 1'b0;
        end else begin
            anyLowPrev <= anyLow;
            ackPending <= next_ackPending;
            wakePendingFlag <= next_pending;
            if (writeEnable) begin
                pinWakeEnable <= regWdata[PIN_COUNT-1:0];
            end
            if (writeStatus) begin
                wakeIrqMask <= regWdata[BIT_MASK];
                sensitivitySelect <= regWdata[BIT_SENSITIVITY];
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Ack bit and bits 7-4 read zero; unmapped reads give zero
    wire [7:0] statusValue = {4'h0, wakePendingFlag, 1'b0, wakeIrqMask,
        sensitivitySelect};
    wire [7:0] enableValue = {3'h0, pinWakeEnable};
    wire [7:0] readMux = selStatus ? statusValue : (selEnable ? enableValue : 8'h00);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRead ? readMux : 8'h00;
        end
    end

    // ----------------------------------------
    // Pin control and interrupt
    // ----------------------------------------
    assign pullupEnable = pinWakeEnable;
    assign pinDirection = portDirection & ~pinWakeEnable;
    // Runs on the bus clock alone, so it stays live in wait and stop
    assign cpuIrq = wakePendingFlag && !wakeIrqMask;

    // ----------------------------------------
    // Check sequences
    // ----------------------------------------
    sequence s_fall;
        anyLow && !anyLowPrev;
    endsequence

    sequence s_edge_ack;
        !sensitivitySelect && ackEvent && !fallEvent;
    endsequence

    sequence s_level_ack;
        sensitivitySelect && wakePendingFlag && ackEvent && anyLow;
    endsequence

    sequence s_level_release;
        sensitivitySelect && wakePendingFlag && ackHeld && !anyLow;
    endsequence

    sequence s_status_read;
        regRead && selStatus;
    endsequence

    sequence s_enable_read;
        regRead && selEnable;
    endsequence

    sequence s_other_read;
        regRead && !selStatus && !selEnable;
    endsequence

    sequence s_guarded_ack_write;
        writeStatus && regWdata[BIT_ACK] && !ack_allowed(breakActive, breakClearEnable);
    endsequence

    sequence s_break_clear_write;
        writeStatus && regWdata[BIT_ACK] && breakActive && breakClearEnable;
    endsequence

    sequence s_sync_split;
        syncB != syncC;
    endsequence

    sequence s_sync_agree;
        syncB == syncC;
    endsequence

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_irq_gate;
        @(posedge clk_sys) disable iff (!rstn)
        (writeStatus && regWdata[BIT_MASK]) |=> !cpuIrq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by mask");

    property p_fall_latch;
        @(posedge clk_sys) disable iff (!rstn)
        (anyLow && !anyLowPrev) |=> wakePendingFlag;
    endproperty
    a_fall_latch: assert property (p_fall_latch) else $error("fall not latched");

    property p_edge_ack;
        @(posedge clk_sys) disable iff (!rstn)
        (vectorFetchAck && !sensitivitySelect && !(anyLow && !anyLowPrev))
            |=> !wakePendingFlag;
    endproperty
    a_edge_ack: assert property (p_edge_ack) else $error("edge ack did not clear");

    property p_level_hold;
        @(posedge clk_sys) disable iff (!rstn)
        (sensitivitySelect && anyLow) |=> wakePendingFlag;
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level lost");

    property p_break_protect;
        @(posedge clk_sys) disable iff (!rstn)
        (wakePendingFlag && breakActive && !breakClearEnable && !vectorFetchAck && !ackPending)
            |=> wakePendingFlag;
    endproperty
    a_break_protect: assert property (p_break_protect) else $error("flag lost in break");

    property p_read_zero;
        @(posedge clk_sys) disable iff (!rstn)
        (regRead && selStatus) |=> (regRdata[7:4] == 4'h0 && !regRdata[BIT_ACK]);
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("reserved bits set");

    property p_disabled_quiet;
        @(posedge clk_sys) disable iff (!rstn)
        (pinWakeEnable == 5'h00 && !wakePendingFlag) |=> !wakePendingFlag;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled pin latched");

    property p_input_force;
        @(posedge clk_sys) disable iff (!rstn)
        writeEnable |=> ((pinDirection & $past(regWdata[PIN_COUNT-1:0])) == 5'h00)
            && (pullupEnable == $past(regWdata[PIN_COUNT-1:0]));
    endproperty
    a_input_force: assert property (p_input_force) else $error("enabled pin drives");

    property p_enable_read;
        @(posedge clk_sys) disable iff (!rstn)
        s_enable_read |=> regRdata == {3'h0, $past(pinWakeEnable)};
    endproperty
    a_enable_read: assert property (p_enable_read) else $error("enable readback wrong");

    property p_edge_block;
        @(posedge clk_sys) disable iff (!rstn)
        (!sensitivitySelect && !wakePendingFlag && anyLow && anyLowPrev) |=> !wakePendingFlag;
    endproperty
    a_edge_block: assert property (p_edge_block) else $error("edge latched while low");

    property p_edge_ack_clear;
        @(posedge clk_sys) disable iff (!rstn)
        s_edge_ack |=> !wakePendingFlag;
    endproperty
    a_edge_ack_clear: assert property (p_edge_ack_clear) else $error("edge ack kept flag");

    property p_level_release;
        @(posedge clk_sys) disable iff (!rstn)
        s_level_release |=> !wakePendingFlag;
    endproperty
    a_level_release: assert property (p_level_release) else $error("level not released");

    property p_level_no_ack;
        @(posedge clk_sys) disable iff (!rstn)
        (sensitivitySelect && wakePendingFlag && !ackHeld) |=> wakePendingFlag;
    endproperty
    a_level_no_ack: assert property (p_level_no_ack) else $error("level cleared no ack");

    property p_ack_memory;
        @(posedge clk_sys) disable iff (!rstn)
        s_level_ack |=> ackPending;
    endproperty
    a_ack_memory: assert property (p_ack_memory) else $error("level ack forgotten");

    property p_ack_forget;
        @(posedge clk_sys) disable iff (!rstn)
        !sensitivitySelect |=> !ackPending;
    endproperty
    a_ack_forget: assert property (p_ack_forget) else $error("ack kept in edge mode");

    property p_fresh_after_ack;
        @(posedge clk_sys) disable iff (!rstn)
        s_edge_ack ##1 s_fall |=> wakePendingFlag;
    endproperty
    a_fresh_after_ack: assert property (p_fresh_after_ack) else $error("edge after ack lost");

    property p_guarded_write;
        @(posedge clk_sys) disable iff (!rstn)
        s_guarded_ack_write ##0 (wakePendingFlag && !vectorFetchAck && !ackPending)
            |=> wakePendingFlag;
    endproperty
    a_guarded_write: assert property (p_guarded_write) else $error("ack in break cleared");

    property p_break_clear;
        @(posedge clk_sys) disable iff (!rstn)
        s_break_clear_write ##0 (!sensitivitySelect && !fallEvent) |=> !wakePendingFlag;
    endproperty
    a_break_clear: assert property (p_break_clear) else $error("break clear ignored");

    property p_cleared_stays;
        @(posedge clk_sys) disable iff (!rstn)
        (!wakePendingFlag && !fallEvent && !levelHold) |=> !wakePendingFlag;
    endproperty
    a_cleared_stays: assert property (p_cleared_stays) else $error("flag set by itself");

    property p_pending_read;
        @(posedge clk_sys) disable iff (!rstn)
        s_status_read |=> regRdata[BIT_PENDING] == $past(wakePendingFlag);
    endproperty
    a_pending_read: assert property (p_pending_read) else $error("pending readback wrong");

    property p_mask_read;
        @(posedge clk_sys) disable iff (!rstn)
        s_status_read |=> regRdata[BIT_MASK] == $past(wakeIrqMask);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");

    property p_mode_read;
        @(posedge clk_sys) disable iff (!rstn)
        s_status_read |=> regRdata[BIT_SENSITIVITY] == $past(sensitivitySelect);
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");

    property p_other_read;
        @(posedge clk_sys) disable iff (!rstn)
        s_other_read |=> regRdata == 8'h00;
    endproperty
    a_other_read: assert property (p_other_read) else $error("unmapped read not zero");

    property p_read_idle;
        @(posedge clk_sys) disable iff (!rstn)
        !regRead |=> regRdata == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data without strobe");

    property p_sync_hold;
        @(posedge clk_sys) disable iff (!rstn)
        s_sync_split |=> pinLevel == $past(pinLevel);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("pin level moved on split");

    property p_sync_follow;
        @(posedge clk_sys) disable iff (!rstn)
        s_sync_agree |=> pinLevel == $past(syncB);
    endproperty
    a_sync_follow: assert property (p_sync_follow) else $error("pin level not taken");

    property p_irq_wake;
        @(posedge clk_sys) disable iff (!rstn)
        (fallEvent && !wakeIrqMask && !writeStatus) |=> cpuIrq;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("unmasked fall no irq");

    property p_mask_quiet;
        @(posedge clk_sys) disable iff (!rstn)
        (wakeIrqMask && !writeStatus) |=> !cpuIrq;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("masked irq raised");

    property p_mode_write;
        @(posedge clk_sys) disable iff (!rstn)
        writeStatus |=> sensitivitySelect == $past(regWdata[BIT_SENSITIVITY]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

endmodule

// File: tb/keypad_switch_model.sv
// Keypad switch model for the wake unit pins
`timescale 1ns/10ps
module keypad_switch_model
    import keypad_wake_pkg::*;
(
    input wire logic [PIN_COUNT-1:0] pressed,
    output logic [PIN_COUNT-1:0] keyPin
);
    // Board pull-ups hold open keys high; closed key shorts to ground
    assign keyPin = ~pressed;
endmodule

// File: tb/keyboard_interrupt_tb_top.sv
// Scenario bench for the keypad wake unit
`timescale 1ns/10ps
module keyboard_interrupt_tb_top
    import keypad_wake_pkg::*;
;
    localparam logic [7:0] SC = ADDR_STATUS_CONTROL;
    localparam logic [7:0] PE = ADDR_PIN_ENABLE;
    logic clk_sys = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0, cpuIrq;
    logic vectorFetchAck = 1'b0, breakActive = 1'b0, breakClearEnable = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
    logic [PIN_COUNT-1:0] pressed = 5'h00, portDirection = 5'h15;
    logic [PIN_COUNT-1:0] keyPin, pullupEnable, pinDirection;
    int err_total = 0, check_count = 0;
    always #2.5 clk_sys = ~clk_sys;
    keypad_switch_model keypad_switch_model_i (.pressed(pressed), .keyPin(keyPin));
    keypad_wake_unit keypad_wake_unit_i (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .keyPin(keyPin), .portDirection(portDirection), .vectorFetchAck(vectorFetchAck),
        .breakActive(breakActive), .breakClearEnable(breakClearEnable),
        .pullupEnable(pullupEnable), .pinDirection(pinDirection), .cpuIrq(cpuIrq));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 chk(regRdata, e);
    endtask
    // Six cycles cover the three-flop sampler and latch
    task key(input logic [PIN_COUNT-1:0] p);
        @(posedge clk_sys);
        pressed <= p;
        repeat (6) @(posedge clk_sys);
    endtask
    task complete_run;
        $display("mismatches %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_init;
        rd(SC, STATUS_CONTROL_RESET);
        rd(PE, 8'h00);
        chk(8'(pinDirection), 8'(portDirection));
        wr(SC, 8'h02);
        wr(PE, 8'h1E);
        wr(SC, 8'h06);
        wr(SC, 8'h00);
        key(5'h01);
        rd(SC, 8'h00);
        chk(8'(pullupEnable), 8'h1E);
        chk(8'(pinDirection), 8'h01);
        key(5'h00);
        wr(PE, 8'h1F);
        rd(PE, 8'h1F);
    endtask
    task t_edge;
        key(5'h01);
        rd(SC, 8'h08);
        chk(8'(cpuIrq), 8'h01);
        wr(SC, 8'h04);
        rd(SC, 8'h00);
        key(5'h03);
        rd(SC, 8'h00);
        key(5'h00);
        key(5'h04);
        rd(SC, 8'h08);
        wr(SC, 8'h02);
        #1 chk(8'(cpuIrq), 8'h00);
        rd(SC, 8'h0A);
        @(posedge clk_sys) vectorFetchAck <= 1'b1;
        @(posedge clk_sys) vectorFetchAck <= 1'b0;
        rd(SC, 8'h02);
        key(5'h00);
    endtask
    task t_level;
        wr(SC, 8'h01);
        key(5'h08);
        wr(SC, 8'h05);
        rd(SC, 8'h09);
        key(5'h00);
        rd(SC, 8'h01);
        key(5'h10);
        key(5'h00);
        rd(SC, 8'h09);
        wr(SC, 8'h05);
        rd(SC, 8'h01);
        key(5'h08);
        @(posedge clk_sys) vectorFetchAck <= 1'b1;
        @(posedge clk_sys) vectorFetchAck <= 1'b0;
        rd(SC, 8'h09);
        key(5'h00);
        rd(SC, 8'h01);
    endtask
    task t_break;
        wr(SC, 8'h00);
        key(5'h01);
        @(posedge clk_sys) breakActive <= 1'b1;
        wr(SC, 8'h04);
        rd(SC, 8'h08);
        @(posedge clk_sys) breakClearEnable <= 1'b1;
        wr(SC, 8'h04);
        @(posedge clk_sys) breakActive <= 1'b0;
        rd(SC, 8'h00);
        key(5'h00);
    endtask
    task t_misc;
        wr(SC, 8'hF3);
        rd(SC, 8'h03);
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        rd(PE, 8'h1F);
        wr(SC, 8'h01);
        key(5'h08);
        @(posedge clk_sys) rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(8'(cpuIrq), 8'h00);
        rstn <= 1'b1;
        rd(SC, 8'h00);
        rd(PE, 8'h00);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        t_init();
        t_edge();
        t_level();
        t_break();
        t_misc();
        complete_run();
    end
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
endmodule
